/* File: core/iap_flash_ctrl.sv */
`include "iap_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module iap_flash_ctrl #(
    parameter int OP_CYCLES     = `IAP_OP_TIME_NS / `IAP_CLK_PERIOD_NS,
    parameter int UNLOCK_CYCLES = `IAP_UNLOCK_TIME_NS / `IAP_CLK_PERIOD_NS,
    parameter int READ_CYCLES   = `IAP_READ_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // software register strobes and levels
    input  wire logic [2:0]  operationMode,
    input  wire logic        readEnableBit,
    input  wire logic [7:0]  wrByte,
    input  wire logic        data0LowWr,
    input  wire logic        data0HighWr,
    input  wire logic [2:0]  keyLowWr,
    input  wire logic [2:0]  keyHighWr,
    input  wire logic        addrLowWr,
    input  wire logic        addrHighWr,
    input  wire logic        unlockTriggerSet,
    input  wire logic        writeInitiateSet,
    input  wire logic        readInitiateSet,
    input  wire logic        bufferClearSet,
    input  wire logic        enableStatusClear,
    // status seen by software
    output logic             unlockTrigger,
    output logic             enableStatus,
    output logic             writeInitiate,
    output logic             readInitiate,
    output logic             bufferClear,
    output logic             cpuStall,
    output logic [15:0]      data0Out,
    output logic [13:0]      flashAddress,
    // flash array side
    output logic             arrPageErase,
    output logic             arrWordWe,
    output logic             arrRead,
    output logic [13:0]      arrAddr,
    output logic [15:0]      arrWrData,
    input  wire logic [15:0] arrRdData
);
    localparam int OCW = $clog2(OP_CYCLES + 1);
    localparam int UCW = $clog2(UNLOCK_CYCLES + 1);
    localparam int RCW = $clog2(READ_CYCLES + 1);

    // the page is streamed inside the operation time, so it must outlast it
    if (OP_CYCLES <= `IAP_PAGE_WORDS || UNLOCK_CYCLES < 1 ||
        READ_CYCLES < 2)
    begin : g_badTiming
        $error("iap_flash_ctrl: timing parameters out of range");
    end

    iap_pkg::iap_state_t state_reg;
    logic [OCW-1:0] opCnt_reg;
    logic [UCW-1:0] unlockCnt_reg;
    logic [RCW-1:0] readCnt_reg;
    logic [2:0]     keyStep_reg;
    logic           keyFail_reg;
    logic           unlockTrigger_reg;
    logic           enableStatus_reg;
    logic           writeInitiate_reg;
    logic           readInitiate_reg;
    logic           bufferClear_reg;
    logic           cpuStall_reg;
    logic [7:0]     data0Low_reg;
    logic [15:0]    data0_reg;
    logic [13:0]    addr_reg;
    logic [5:0]     wbIdx_reg;
    logic [15:0]    wbMem [`IAP_PAGE_WORDS];
    logic [`IAP_PAGE_WORDS-1:0] wbValid_reg;
    logic           arrPageErase_reg;
    logic           arrWordWe_reg;
    logic           arrRead_reg;
    logic [13:0]    arrAddr_reg;
    logic [15:0]    arrWrData_reg;

    function automatic logic [7:0] keyByte(input logic [2:0] step);
        unique case (step)
            3'h0:    keyByte = `IAP_KEY0;
            3'h1:    keyByte = `IAP_KEY1;
            3'h2:    keyByte = `IAP_KEY2;
            3'h3:    keyByte = `IAP_KEY3;
            3'h4:    keyByte = `IAP_KEY4;
            3'h5:    keyByte = `IAP_KEY5;
            default: keyByte = 8'hFF;
        endcase
    endfunction : keyByte

    // low registers one to three come first, then the high ones
    function automatic logic [2:0] keySlot(input logic [2:0] lo,
                                           input logic [2:0] hi);
        keySlot = 3'h7;
        for (int i = 2; i >= 0; i--)
        begin
            if (hi[i])
                keySlot = 3'(3 + i);
        end
        for (int i = 2; i >= 0; i--)
        begin
            if (lo[i])
                keySlot = 3'(i);
        end
    endfunction : keySlot

    logic busy;
    logic keyWrite;
    logic keyMatch;
    logic keyGood;
    logic loadWord;
    logic wrAccept;
    logic rdAccept;
    logic opDone;
    logic rdDone;
    logic [2:0] slot;

    // the processor is stalled while busy, so its strobes are dropped
    assign busy     = writeInitiate_reg | readInitiate_reg;
    assign keyWrite = !busy && ((|keyLowWr) || (|keyHighWr));
    assign slot     = keySlot(keyLowWr, keyHighWr);
    assign keyMatch = slot == keyStep_reg && wrByte == keyByte(keyStep_reg);
    // late keys never count: the trigger is gone once the timer ends
    assign keyGood  = keyWrite && unlockTrigger_reg && !keyFail_reg &&
                      keyMatch && keyStep_reg == 3'h5;
    assign loadWord = !busy && data0HighWr;
    assign wrAccept = !busy && writeInitiateSet && enableStatus_reg &&
                      (operationMode == `IAP_MODE_WRITE ||
                       operationMode == `IAP_MODE_ERASE);
    assign rdAccept = !busy && readInitiateSet && readEnableBit &&
                      operationMode == `IAP_MODE_READ;
    assign opDone   = opCnt_reg == OCW'(OP_CYCLES - 1);
    assign rdDone   = readCnt_reg == '0;

    // unlock trigger and its timer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) begin
            unlockTrigger_reg <= 1'b0;
            unlockCnt_reg     <= '0;
        end else if (ce) begin
            if (unlockTrigger_reg) begin
                unlockCnt_reg <= unlockCnt_reg - 1'b1;
                if (unlockCnt_reg == UCW'(1))
                    unlockTrigger_reg <= 1'b0;
            end else if (unlockTriggerSet && !busy &&
                         operationMode == `IAP_MODE_UNLOCK) begin
                unlockTrigger_reg <= 1'b1;
                unlockCnt_reg     <= UCW'(UNLOCK_CYCLES);
            end
        end
    end

    // key pattern tracking
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) begin
            keyStep_reg <= 3'h0;
            keyFail_reg <= 1'b0;
        end else if (ce) begin
            if (!unlockTrigger_reg) begin
                keyStep_reg <= 3'h0;
                keyFail_reg <= 1'b0;
            end else if (keyWrite) begin
                if (keyMatch && keyStep_reg != 3'h5)
                    keyStep_reg <= keyStep_reg + 3'h1;
                else if (!keyMatch)
                    keyFail_reg <= 1'b1;
            end
        end
    end

    // enable status: the hardware set wins over a software clear
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            enableStatus_reg <= 1'b0;
        else if (ce) begin
            if (keyGood)
                enableStatus_reg <= 1'b1;
            else if (enableStatusClear && !busy)
                enableStatus_reg <= 1'b0;
        end
    end

    // address pair and data0
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) begin
            addr_reg     <= '0;
            data0Low_reg <= 8'h00;
            data0_reg    <= 16'h0000;
        end else if (ce) begin
            if (state_reg == iap_pkg::ST_READ && rdDone)
                data0_reg <= arrRdData;
            else if (!busy && data0LowWr) begin
                data0Low_reg      <= wrByte;
                data0_reg[7:0]    <= wrByte;
            end else if (!busy && data0HighWr)
                data0_reg[15:8] <= wrByte;
            if (!busy && addrLowWr)
                addr_reg[7:0] <= wrByte;
            else if (!busy && addrHighWr)
                addr_reg[13:8] <= wrByte[5:0];
            else if (loadWord)
                addr_reg <= addr_reg + 14'h1;
        end
    end

    // page write buffer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) begin
            wbIdx_reg       <= 6'h00;
            wbValid_reg     <= '0;
            bufferClear_reg <= 1'b0;
        end else if (ce) begin
            if (bufferClear_reg) begin
                wbValid_reg     <= '0;
                bufferClear_reg <= 1'b0;
            end else if (bufferClearSet && !busy)
                bufferClear_reg <= 1'b1;
            if (!busy && addrLowWr)
                wbIdx_reg <= wrByte[5:0];
            else if (loadWord) begin
                wbValid_reg[wbIdx_reg] <= 1'b1;
                if (wbIdx_reg != 6'(`IAP_PAGE_WORDS - 1))
                    wbIdx_reg <= wbIdx_reg + 6'h1;
            end
        end
    end

    // storage array has no reset; valid bits qualify it
    always_ff @(posedge clock)
    begin
        if (ce && loadWord)
            wbMem[wbIdx_reg] <= {wrByte, data0Low_reg};
    end

    // operation sequencer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn) begin
            state_reg         <= iap_pkg::ST_IDLE;
            opCnt_reg         <= '0;
            readCnt_reg       <= '0;
            writeInitiate_reg <= 1'b0;
            readInitiate_reg  <= 1'b0;
            cpuStall_reg      <= 1'b0;
            arrPageErase_reg  <= 1'b0;
            arrWordWe_reg     <= 1'b0;
            arrRead_reg       <= 1'b0;
            arrAddr_reg       <= '0;
            arrWrData_reg     <= 16'h0000;
        end else if (ce) begin
            arrPageErase_reg <= 1'b0;
            arrWordWe_reg    <= 1'b0;
            arrRead_reg      <= 1'b0;
            unique case (state_reg)
                iap_pkg::ST_IDLE:
                begin
                    opCnt_reg <= '0;
                    if (wrAccept) begin
                        writeInitiate_reg <= 1'b1;
                        cpuStall_reg      <= 1'b1;
                        arrAddr_reg       <= {addr_reg[13:6], 6'h00};
                        if (operationMode == `IAP_MODE_ERASE) begin
                            state_reg        <= iap_pkg::ST_ERASE;
                            arrPageErase_reg <= 1'b1;
                        end else
                            state_reg <= iap_pkg::ST_PROG;
                    end else if (rdAccept) begin
                        state_reg        <= iap_pkg::ST_READ;
                        readInitiate_reg <= 1'b1;
                        cpuStall_reg     <= 1'b1;
                        readCnt_reg      <= RCW'(READ_CYCLES - 1);
                        arrRead_reg      <= 1'b1;
                        arrAddr_reg      <= addr_reg;
                    end
                end
                iap_pkg::ST_ERASE, iap_pkg::ST_PROG:
                begin
                    opCnt_reg <= opCnt_reg + 1'b1;
                    // the whole page is streamed, untouched words skipped
                    if (state_reg == iap_pkg::ST_PROG &&
                        opCnt_reg < OCW'(`IAP_PAGE_WORDS)) begin
                        arrWordWe_reg <= wbValid_reg[opCnt_reg[5:0]];
                        arrAddr_reg   <= {addr_reg[13:6], opCnt_reg[5:0]};
                        arrWrData_reg <= wbMem[opCnt_reg[5:0]];
                    end
                    if (opDone) begin
                        state_reg         <= iap_pkg::ST_IDLE;
                        writeInitiate_reg <= 1'b0;
                        cpuStall_reg      <= 1'b0;
                    end
                end
                iap_pkg::ST_READ:
                begin
                    readCnt_reg <= readCnt_reg - 1'b1;
                    if (rdDone) begin
                        state_reg        <= iap_pkg::ST_IDLE;
                        readInitiate_reg <= 1'b0;
                        cpuStall_reg     <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign unlockTrigger = unlockTrigger_reg;
    assign enableStatus  = enableStatus_reg;
    assign writeInitiate = writeInitiate_reg;
    assign readInitiate  = readInitiate_reg;
    assign bufferClear   = bufferClear_reg;
    assign cpuStall      = cpuStall_reg;
    assign data0Out      = data0_reg;
    assign flashAddress  = addr_reg;
    assign arrPageErase  = arrPageErase_reg;
    assign arrWordWe     = arrWordWe_reg;
    assign arrRead       = arrRead_reg;
    assign arrAddr       = arrAddr_reg;
    assign arrWrData     = arrWrData_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_trigStart;
        ce && unlockTriggerSet && !busy && !unlockTrigger &&
        operationMode == `IAP_MODE_UNLOCK |=> unlockTrigger;
    endproperty
    a_trigStart: assert property (p_trigStart)
        else $error("unlock trigger not started");

    property p_trigExpire;
        ce && unlockTrigger && unlockCnt_reg == UCW'(1) |=> !unlockTrigger;
    endproperty
    a_trigExpire: assert property (p_trigExpire)
        else $error("unlock trigger not cleared at timeout");

    property p_enableCause;
        $rose(enableStatus) |-> $past(keyGood) && $past(unlockTrigger);
    endproperty
    a_enableCause: assert property (p_enableCause)
        else $error("enable status set without full key pattern");

    property p_disable;
        ce && enableStatusClear && !busy && !keyGood |=> !enableStatus;
    endproperty
    a_disable: assert property (p_disable)
        else $error("enable status not cleared by software");

    property p_idxHold;
        ce && loadWord && !addrLowWr && wbIdx_reg == 6'h3F
            |=> wbIdx_reg == 6'h3F;
    endproperty
    a_idxHold: assert property (p_idxHold)
        else $error("buffer address moved past last word");

    property p_addrInc;
        ce && loadWord && !addrLowWr && !addrHighWr
            |=> flashAddress == $past(flashAddress) + 14'h1;
    endproperty
    a_addrInc: assert property (p_addrInc)
        else $error("address not incremented after word load");

    property p_stall;
        cpuStall == (writeInitiate || readInitiate);
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall does not track initiate bits");

    property p_lockedOp;
        ce && writeInitiateSet && !busy && !enableStatus |=> !writeInitiate;
    endproperty
    a_lockedOp: assert property (p_lockedOp)
        else $error("erase or program started while locked");

    property p_readTime;
        $rose(readInitiate) ##0 ce[*3] |-> ##1 !readInitiate;
    endproperty
    a_readTime: assert property (p_readTime)
        else $error("read initiate did not clear after three cycles");

    property p_eraseStart;
        ce && wrAccept && operationMode == `IAP_MODE_ERASE
            |=> arrPageErase && arrAddr[5:0] == 6'h00;
    endproperty
    a_eraseStart: assert property (p_eraseStart)
        else $error("erase not issued for whole page");

    c_unlock: cover property ($rose(enableStatus));
    c_prog:   cover property (state_reg == iap_pkg::ST_PROG ##1
                              $fell(writeInitiate));
    c_erase:  cover property ($rose(arrPageErase));
    c_read:   cover property ($fell(readInitiate));
endmodule : iap_flash_ctrl
`default_nettype wire

/* File: core/iap_consts.svh */
// Summary of operation
// - unlock mode 110 plus trigger bit set starts the internal unlock timer
// - key bytes 00H 0DH C3H low, then 04H 09H 40H high, in order
// - timer expiry clears the trigger bit whatever pattern was written
// - only a complete correct pattern enables erase/write and sets status
// - software clearing the status bit disables erase/write at once
// - 64-word 16-bit page buffer, page chosen by address bits 13 to 6
// - each low-then-high data write advances the buffer address
// - buffer address holds at the last word of the page
// - mode 001 with write-initiate erases the addressed page, then clears
// - mode 000 with write-initiate programs the buffer, then clears
// - processor stalls while write-initiate is high, about 2.2 ms
// - erase always clears an entire page
// - program writes only the loaded buffer words into one page; software keeps in page
// - mode 011, read enable, address, read-initiate; word lands in data0
// - reads need no unlock and ignore the status bit
// - erase and program only after successful unlock
// - high data byte write loads the word and increments address by one
// - status bit is set only by hardware; software one has no effect
// - read-initiate clears about three cycles later, stalling meanwhile
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH

`define IAP_MODE_WRITE   3'h0
`define IAP_MODE_ERASE   3'h1
`define IAP_MODE_READ    3'h3
`define IAP_MODE_UNLOCK  3'h6

`define IAP_KEY0 8'h00
`define IAP_KEY1 8'h0D
`define IAP_KEY2 8'hC3
`define IAP_KEY3 8'h04
`define IAP_KEY4 8'h09
`define IAP_KEY5 8'h40

`define IAP_CLK_PERIOD_NS 4
`define IAP_OP_TIME_NS     2200000
`define IAP_UNLOCK_TIME_NS 4096
`define IAP_READ_CYCLES    3

`define IAP_PAGE_WORDS 64
`define IAP_ADDR_BITS  14
`define IAP_PAGE_LSB   6

`endif

/* File: core/iap_pkg.sv */
package iap_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG,
        ST_READ
    } iap_state_t;
endpackage : iap_pkg

/* File: verification/iap_flash_array_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iap_flash_array_model #(
    parameter int RD_DELAY = 1
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // commands from the controller
    input  wire logic        arrPageErase,
    input  wire logic        arrWordWe,
    input  wire logic        arrRead,
    input  wire logic [13:0] arrAddr,
    input  wire logic [15:0] arrWrData,
    // read word
    output logic      [15:0] arrRdData
);
    logic [15:0] mem [0:16383];
    logic [15:0] rdWord;
    logic [15:0] noise;
    int          rdAge;

    // unprogrammed cells differ from the erased level so erase shows
    initial
    begin
        for (int i = 0; i < 16384; i++)
            mem[i] = 16'hFFFF;
    end

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rdAge <= 0;
            noise <= 16'h5A5A;
        end
        else
        begin
            noise <= ~noise + 16'h0001;
            if (arrPageErase)
                for (int i = 0; i < 64; i++)
                    mem[{arrAddr[13:6], 6'(i)}] <= 16'h0000;
            if (arrWordWe)
                mem[arrAddr] <= arrWrData;
            if (arrRead)
            begin
                rdWord <= mem[arrAddr];
                rdAge  <= 1;
            end
            else if (rdAge != 0 && rdAge < 4)
                rdAge <= rdAge + 1;
            else
                rdAge <= 0;
        end
    end

    // outside the hold window the bus carries a moving pattern
    assign arrRdData = (rdAge > RD_DELAY) ? rdWord : noise;
endmodule : iap_flash_array_model
`default_nettype wire

/* File: verification/testbench.sv */
`include "iap_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int OP  = 100;
    localparam int UNL = 32;
    localparam int RDC = 3;

    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic [2:0]  operationMode = 3'h0;
    logic        readEnableBit = 1'b0;
    logic [7:0]  wrByte = 8'h00;
    logic        data0LowWr = 1'b0;
    logic        data0HighWr = 1'b0;
    logic [2:0]  keyLowWr = 3'h0;
    logic [2:0]  keyHighWr = 3'h0;
    logic        addrLowWr = 1'b0;
    logic        addrHighWr = 1'b0;
    logic        unlockTriggerSet = 1'b0;
    logic        writeInitiateSet = 1'b0;
    logic        readInitiateSet = 1'b0;
    logic        bufferClearSet = 1'b0;
    logic        enableStatusClear = 1'b0;
    logic        unlockTrigger, enableStatus, writeInitiate, readInitiate;
    logic        bufferClear, cpuStall, arrPageErase, arrWordWe, arrRead;
    logic [15:0] data0Out, arrWrData, arrRdData;
    logic [13:0] flashAddress, arrAddr;
    int          fails = 0;
    int          samplesChecked = 0;
    int          stallCnt, trigCnt, weCnt, erCnt;
    int          seed = 32'h0C3222B3;
    int          flashExp[int];
    int          bufExp[int];

    iap_flash_ctrl #(.OP_CYCLES(OP), .UNLOCK_CYCLES(UNL), .READ_CYCLES(RDC))
    DUT (.clock(clock), .rstn(rstn), .ce(ce), .operationMode(operationMode),
        .readEnableBit(readEnableBit), .wrByte(wrByte),
        .data0LowWr(data0LowWr), .data0HighWr(data0HighWr),
        .keyLowWr(keyLowWr), .keyHighWr(keyHighWr), .addrLowWr(addrLowWr),
        .addrHighWr(addrHighWr), .unlockTriggerSet(unlockTriggerSet),
        .writeInitiateSet(writeInitiateSet),
        .readInitiateSet(readInitiateSet), .bufferClearSet(bufferClearSet),
        .enableStatusClear(enableStatusClear), .unlockTrigger(unlockTrigger),
        .enableStatus(enableStatus), .writeInitiate(writeInitiate),
        .readInitiate(readInitiate), .bufferClear(bufferClear),
        .cpuStall(cpuStall), .data0Out(data0Out), .flashAddress(flashAddress),
        .arrPageErase(arrPageErase), .arrWordWe(arrWordWe), .arrRead(arrRead),
        .arrAddr(arrAddr), .arrWrData(arrWrData), .arrRdData(arrRdData));

    iap_flash_array_model #(.RD_DELAY(1)) flashArray (.clock(clock),
        .rstn(rstn), .arrPageErase(arrPageErase), .arrWordWe(arrWordWe),
        .arrRead(arrRead), .arrAddr(arrAddr), .arrWrData(arrWrData),
        .arrRdData(arrRdData));

    always #2 clock = ~clock;

    // cycle counters sample pre-edge values, so a level high n cycles counts n
    always @(posedge clock)
    begin
        if (cpuStall === 1'b1)
            stallCnt++;
        if (unlockTrigger === 1'b1)
            trigCnt++;
        if (arrWordWe === 1'b1)
            weCnt++;
        if (arrPageErase === 1'b1)
            erCnt++;
    end

    task automatic summarize;
        $display("checked %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chkWord(input logic [15:0] got, input logic [15:0] want);
        samplesChecked++;
        if (got !== want)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chkWord

    task automatic chkNum(input int got, input int want);
        samplesChecked++;
        if (got != want)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chkNum

    // one software register write: strobe for one cycle, then idle one
    task automatic sw(input int s, input logic [7:0] b);
        @(posedge clock);
        wrByte <= b;
        case (s)
            0: data0LowWr <= 1'b1;
            1: data0HighWr <= 1'b1;
            2, 3, 4: keyLowWr[s-2] <= 1'b1;
            5, 6, 7: keyHighWr[s-5] <= 1'b1;
            8: addrLowWr <= 1'b1;
            9: addrHighWr <= 1'b1;
            10: unlockTriggerSet <= 1'b1;
            11: writeInitiateSet <= 1'b1;
            12: readInitiateSet <= 1'b1;
            13: bufferClearSet <= 1'b1;
            default: enableStatusClear <= 1'b1;
        endcase
        @(posedge clock);
        {data0LowWr, data0HighWr, keyLowWr, keyHighWr, addrLowWr, addrHighWr,
            unlockTriggerSet, writeInitiateSet, readInitiateSet,
            bufferClearSet, enableStatusClear} <= 15'h0000;
        #1;
    endtask : sw

    task automatic waitIdle;
        int n;
        n = 0;
        while ((cpuStall === 1'b1 || unlockTrigger === 1'b1) && n < 1000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 1000)
        begin
            fails++;
            summarize();
        end
    endtask : waitIdle

    task automatic keys(input logic [7:0] last);
        sw(2, `IAP_KEY0);
        sw(3, `IAP_KEY1);
        sw(4, `IAP_KEY2);
        sw(5, `IAP_KEY3);
        sw(6, `IAP_KEY4);
        sw(7, last);
    endtask : keys

    task automatic setAddr(input logic [13:0] a);
        sw(8, a[7:0]);
        sw(9, {2'b00, a[13:8]});
        chkWord({2'b00, flashAddress}, {2'b00, a});
    endtask : setAddr

    task automatic load(input logic [15:0] w);
        sw(0, w[7:0]);
        sw(1, w[15:8]);
        chkWord(data0Out, w);
    endtask : load

    task automatic startOp(input logic [2:0] m, input int s);
        @(posedge clock) operationMode <= m;
        stallCnt = 0;
        weCnt = 0;
        erCnt = 0;
        sw(s, 8'h00);
        waitIdle();
    endtask : startOp

    task automatic progPage(input logic [13:0] base);
        setAddr(base);
        startOp(`IAP_MODE_WRITE, 11);
        chkNum(stallCnt, OP);
        chkNum(weCnt, bufExp.num());
        foreach (bufExp[i])
            flashExp[{base[13:6], 6'(i)}] = bufExp[i];
    endtask : progPage

    task automatic rd(input logic [13:0] a);
        setAddr(a);
        startOp(`IAP_MODE_READ, 12);
        chkNum(stallCnt, RDC);
        chkWord(data0Out, 16'(flashExp[a]));
    endtask : rd

    initial
    begin
        #240000;
        fails++;
        summarize();
    end

    initial
    begin
        logic [7:0]  pg;
        logic [13:0] base;
        logic [15:0] w;
        pg = 8'($random(seed));
        base = {pg, 6'h00};
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chkWord({15'h0000, enableStatus}, 16'h0000);
        startOp(`IAP_MODE_ERASE, 11);
        chkNum(erCnt, 0);
        @(posedge clock) operationMode <= `IAP_MODE_UNLOCK;
        trigCnt = 0;
        sw(10, 8'h00);
        chkWord({15'h0000, unlockTrigger}, 16'h0001);
        keys(8'h41);
        chkWord({15'h0000, enableStatus}, 16'h0000);
        waitIdle();
        chkNum(trigCnt, UNL);
        keys(`IAP_KEY5);
        chkWord({15'h0000, enableStatus}, 16'h0000);
        trigCnt = 0;
        sw(10, 8'h00);
        keys(`IAP_KEY5);
        chkWord({15'h0000, enableStatus}, 16'h0001);
        waitIdle();
        chkNum(trigCnt, UNL);
        // erase from a mid-page address: the whole page must clear
        setAddr({pg, 6'h2A});
        startOp(`IAP_MODE_ERASE, 11);
        chkNum(stallCnt, OP);
        chkNum(erCnt, 1);
        for (int i = 0; i < 64; i++)
            flashExp[{pg, 6'(i)}] = 0;
        @(posedge clock) readEnableBit <= 1'b1;
        rd(base);
        @(posedge clock) operationMode <= `IAP_MODE_WRITE;
        setAddr(base);
        for (int k = 0; k < 66; k++)
        begin
            w = 16'($random(seed));
            load(w);
            bufExp[k < 63 ? k : 63] = w;
            if (k < 63)
                chkWord({2'b00, flashAddress}, {2'b00, base + 14'(k + 1)});
        end
        progPage(base);
        for (int i = 0; i < 64; i++)
            rd(base + 14'(i));
        @(posedge clock) readEnableBit <= 1'b0;
        sw(13, 8'h00);
        chkWord({15'h0000, bufferClear}, 16'h0001);
        bufExp.delete();
        setAddr(base + 14'd5);
        w = 16'($random(seed));
        load(w);
        bufExp[5] = w;
        setAddr(base + 14'd40);
        w = 16'($random(seed));
        load(w);
        bufExp[40] = w;
        progPage(base);
        sw(14, 8'h00);
        chkWord({15'h0000, enableStatus}, 16'h0000);
        startOp(`IAP_MODE_ERASE, 11);
        chkNum(erCnt, 0);
        startOp(`IAP_MODE_READ, 12);
        chkNum(stallCnt, 0);
        @(posedge clock) readEnableBit <= 1'b1;
        // a read frozen by the clock enable for five cycles stalls five longer
        stallCnt = 0;
        sw(12, 8'h00);
        @(posedge clock) ce <= 1'b0;
        repeat (5) @(posedge clock);
        ce <= 1'b1;
        waitIdle();
        chkNum(stallCnt, RDC + 5);
        rd(base + 14'd5);
        rd(base + 14'd40);
        rd(base + 14'd6);
        summarize();
    end
endmodule : testbench
`default_nettype wire
